// file: bench/dsc_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Link-side pin checks
// ****************************************
module dsc_core_chk (
  // Link clock and reset
  input wire logic link_clock,
  input wire logic reset,
  // Command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  // Pad and clocking outputs
  input wire logic dq_oe,
  input wire logic dqs_oe,
  input wire logic dqs_n_oe,
  input wire logic term_on,
  input wire logic inbuf_cmd_en,
  input wire logic inbuf_odt_en,
  input wire logic clk_run
);
  default clocking cb @(posedge link_clock); endclocking
  default disable iff (reset);
  logic rd_now;
  logic [10:0] rd_hist;
  // Read accepted at this edge
  assign rd_now = inbuf_cmd_en && cke && !cs_n && ras_n && !cas_n && we_n;
  // Accepted reads, bit k is k+1 edges back
  always_ff @(posedge link_clock or posedge reset) begin
    if (reset) begin
      rd_hist <= '0;
    end else begin
      rd_hist <= {rd_hist[9:0], rd_now};
    end
  end
  sequence rd_s;
    rd_now;
  endsequence
  sequence burst_s;
    dq_oe [*2];
  endsequence
  term_rise_a: assert property ($rose(term_on) |-> $past(odt) || $past(odt, 2))
    else $error("termination on without request");
  read_lat_a: assert property (rd_s |-> ##[4:11] dq_oe)
    else $error("read data missing");
  read_cause_a: assert property ($rose(dq_oe) |-> |rd_hist[10:3])
    else $error("read data without read");
  burst_hold_a: assert property ($rose(dq_oe) |-> burst_s)
    else $error("burst too short");
  strobe_pair_a: assert property (dqs_oe == dq_oe)
    else $error("strobe not with data");
  diff_strobe_a: assert property (dqs_n_oe |-> dqs_oe)
    else $error("complement strobe alone");
  clk_stop_a: assert property ($fell(clk_run) |-> !$past(cke, 2))
    else $error("clocking stopped with clock enable high");
  buf_stop_a: assert property ($fell(inbuf_cmd_en) |-> !$past(cke, 2))
    else $error("buffers off with clock enable high");
  sr_buffers_a: assert property (!inbuf_odt_en |-> !inbuf_cmd_en)
    else $error("command buffers on in self refresh");
endmodule // dsc_core_chk
bind dsc_core dsc_core_chk u_chk (.link_clock, .reset, .cke, .cs_n, .ras_n, .cas_n, .we_n,
  .odt, .dq_oe, .dqs_oe, .dqs_n_oe, .term_on, .inbuf_cmd_en, .inbuf_odt_en, .clk_run);
`default_nettype wire

// file: bench/dsc_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end
module dsc_core_tb;
  import dsc_pkg::*;
  localparam int DQ_W = 72;
  localparam int DIES = 5;
  // ****************************************
  // Clocks, wiring and instances
  // ****************************************
  logic clock = 1'b0;
  logic link_clock = 1'b0;
  logic reset = 1'b1;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic cke, cs_n, ras_n, cas_n, we_n, odt, dq_oe, dqs_oe, dqs_n_oe, term_on;
  logic inbuf_cmd_en, inbuf_odt_en, clk_run, stat_term, stat_burst8;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dq_rise, dq_fall, dq_out_rise, dq_out_fall;
  logic [2*DIES-1:0] dm_rise, dm_fall;
  logic [1:0] stat_power;
  logic [BANKS-1:0] stat_banks;
  logic [LAT_W-1:0] stat_cas_lat, stat_add_lat;
  dsc_core #(.DQ_W(DQ_W), .DIES(DIES), .PIPE_D(9)) DUT (.clock, .reset, .link_clock, .cke,
    .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .odt, .dq_rise, .dq_fall, .dm_rise, .dm_fall,
    .dq_out_rise, .dq_out_fall, .dq_oe, .dqs_oe, .dqs_n_oe, .term_on, .inbuf_cmd_en,
    .inbuf_odt_en, .clk_run, .stat_power, .stat_banks, .stat_term, .stat_burst8,
    .stat_cas_lat, .stat_add_lat);
  dsc_ctl_model #(.DQ_W(DQ_W), .DIES(DIES)) ctl (.link_clock, .cke, .cs_n, .ras_n, .cas_n,
    .we_n, .ba, .addr, .odt, .dq_rise, .dq_fall, .dm_rise, .dm_fall);
  // Core clock, 40 ns
  always #20 clock = ~clock;
  // Link clock, 48 ns, offset from the core clock
  initial begin
    #7;
    forever #24 link_clock = ~link_clock;
  end
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [DQ_W-1:0] mix(input logic [7:0] s_old, input logic [7:0] s_new,
      input int k, input logic [2*DIES-1:0] mask);
    logic [DQ_W-1:0] r;
    r = {(DQ_W / 8){s_new + 8'(k)}};
    for (int b = 0; b < DQ_W / 8; b++) begin
      if (mask[b]) r[8*b +: 8] = s_old + 8'(k);
    end
    return r;
  endfunction
  // Let status cross into the core domain
  task automatic settle();
    repeat (12) @(negedge clock);
  endtask
  // Read burst; odd beats may carry older bytes where a write was masked
  task automatic read_check(input logic [BA_W-1:0] b, input int rl, input int cyc,
      input logic [7:0] s_new, input logic [7:0] s_old, input logic [2*DIES-1:0] mask,
      input logic diff);
    ctl.issue(1'b0, CODE_READ, b, '0);
    repeat (rl) @(negedge link_clock);
    for (int i = 0; i < cyc; i++) begin
      if (i > 0) @(negedge link_clock);
      `CHECK(dq_oe, 1'b1)
      `CHECK(dqs_oe, 1'b1)
      `CHECK(dqs_n_oe, diff)
      `CHECK(dq_out_rise, mix(s_new, s_new, 2 * i, '0))
      `CHECK(dq_out_fall, mix(s_old, s_new, 2 * i + 1, mask))
    end
    @(negedge link_clock);
    `CHECK(dq_oe, 1'b0)
  endtask
  task automatic power_check(input logic c, input int n, input logic [1:0] pw);
    ctl.cke = c;
    repeat (n) @(negedge link_clock);
    settle();
    `CHECK(stat_power, pw)
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(negedge clock);
    `CHECK({term_on, inbuf_cmd_en, clk_run, stat_power}, 5'h0c)
    reset = 1'b0;
    settle();
    `CHECK({stat_burst8, stat_cas_lat}, 4'h4)
    ctl.issue(1'b0, CODE_ACTIVE, 2'h1, '0);
    ctl.issue(1'b0, CODE_ACTIVE, 2'h2, '0);
    settle();
    `CHECK(stat_banks, 4'h6)
    ctl.write_burst(2'h1, 3, 2, 8'h10, '0);
    ctl.write_burst(2'h1, 3, 2, 8'h40, 10'h005);
    ctl.write_burst(2'h2, 3, 2, 8'h70, '0);
    read_check(2'h1, 4, 2, 8'h40, 8'h10, 10'h005, 1'b1);
    read_check(2'h2, 4, 2, 8'h70, 8'h70, '0, 1'b1);
    ctl.issue(1'b1, CODE_READ, 2'h1, '0);
    for (int i = 0; i < 8; i++) begin
      @(negedge link_clock);
      `CHECK(dq_oe, 1'b0)
    end
    ctl.issue(1'b0, CODE_MODE, 2'h1, 13'h0014);
    ctl.odt = 1'b1;
    repeat (3) @(negedge link_clock);
    `CHECK(term_on, 1'b1)
    settle();
    `CHECK({stat_term, stat_add_lat}, 4'ha)
    ctl.issue(1'b0, CODE_MODE, 2'h0, 13'h0053);
    settle();
    `CHECK({stat_burst8, stat_cas_lat}, 4'hd)
    ctl.write_burst(2'h1, 6, 4, 8'h20, '0);
    read_check(2'h1, 7, 4, 8'h20, 8'h20, '0, 1'b1);
    ctl.issue(1'b0, CODE_MODE, 2'h1, 13'h0410);
    repeat (3) @(negedge link_clock);
    `CHECK(term_on, 1'b0)
    ctl.odt = 1'b0;
    read_check(2'h1, 7, 4, 8'h20, 8'h20, '0, 1'b0);
    ctl.issue(1'b0, CODE_PRECHARGE, 2'h1, 13'h0000);
    settle();
    `CHECK(stat_banks, 4'h4)
    power_check(1'b0, 3, 2'h2);
    `CHECK({clk_run, inbuf_cmd_en, inbuf_odt_en}, 3'h1)
    power_check(1'b1, 3, 2'h0);
    ctl.issue(1'b0, CODE_PRECHARGE, 2'h0, 13'h0400);
    settle();
    `CHECK(stat_banks, 4'h0)
    power_check(1'b0, 3, 2'h1);
    power_check(1'b1, 3, 2'h0);
    fork
      ctl.issue(1'b0, CODE_REFRESH, 2'h0, '0);
      begin
        @(negedge link_clock);
        ctl.cke = 1'b0;
      end
    join
    power_check(1'b0, 3, 2'h3);
    `CHECK({inbuf_cmd_en, inbuf_odt_en}, 2'h0)
    power_check(1'b1, 4, 2'h0);
    `CHECK(clk_run, 1'b1)
    end_of_test();
  end
endmodule // dsc_core_tb
`default_nettype wire

// file: bench/dsc_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Memory controller at the pins
// ****************************************
module dsc_ctl_model import dsc_pkg::*; #(
  parameter int DQ_W = 72,
  parameter int DIES = 5
) (
  // Memory clock
  input wire logic link_clock,
  // Command and control pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [BA_W-1:0] ba,
  output logic [ADDR_W-1:0] addr,
  output logic odt,
  // Write beats and masks
  output logic [DQ_W-1:0] dq_rise,
  output logic [DQ_W-1:0] dq_fall,
  output logic [2*DIES-1:0] dm_rise,
  output logic [2*DIES-1:0] dm_fall
);
  logic quiet;
  // Idle pins, clock enable up before reset ends
  initial begin
    quiet = 1'b1;
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = '0;
    addr = '0;
    odt = 1'b0;
    {dq_rise, dq_fall, dm_rise, dm_fall} = '0;
  end
  // Released data lines toggle so stale beats never look valid
  always @(negedge link_clock) begin
    if (quiet) begin
      {dq_rise, dq_fall, dm_rise, dm_fall} = ~{dq_rise, dq_fall, dm_rise, dm_fall};
    end
  end
  // One command, held across the rising edge, then deselect
  task automatic issue(input logic sel_n, input logic [2:0] code, input logic [BA_W-1:0] b,
      input logic [ADDR_W-1:0] a);
    @(negedge link_clock);
    cs_n = sel_n;
    {ras_n, cas_n, we_n} = code;
    ba = b;
    addr = a;
    @(negedge link_clock);
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
  endtask
  // Write burst with beats placed at the write latency
  task automatic write_burst(input logic [BA_W-1:0] b, input int wl, input int cyc,
      input logic [7:0] seed, input logic [2*DIES-1:0] mask);
    issue(1'b0, CODE_WRITE, b, '0);
    // Stop idle toggling one edge early so no line is driven twice at once
    repeat (wl - 2) @(negedge link_clock);
    quiet = 1'b0;
    @(negedge link_clock);
    for (int i = 0; i < cyc; i++) begin
      if (i > 0) @(negedge link_clock);
      dq_rise = {(DQ_W / 8){seed + 8'(2 * i)}};
      dq_fall = {(DQ_W / 8){seed + 8'(2 * i + 1)}};
      dm_rise = '0;
      dm_fall = mask;
    end
    @(negedge link_clock);
    quiet = 1'b1;
  endtask
endmodule // dsc_ctl_model
`default_nettype wire

// file: src/dsc_cmd_if.sv
`timescale 1ns/1ps
`default_nettype none
// Registered command strobes and their decoded command
interface dsc_cmd_if;
  import dsc_pkg::*;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  dsc_cmd_t cmd;
  modport dec (input cs_n, input ras_n, input cas_n, input we_n, output cmd);
  modport src (output cs_n, output ras_n, output cas_n, output we_n, input cmd);
endinterface
`default_nettype wire

// file: src/dsc_core.sv
// How it works
// - ODT high turns termination on
// - Termination covers data, mask and strobe lines
// - ODT ignored when mode register disables termination
// - Pins sampled on rising link clock
// - Read data and strobes timed by link clock
// - Clock enable starts and stops internal clocking
// - Clock enable low: power-down or self refresh
// - Self refresh exit asynchronous, others synchronous
// - Power-down keeps only clock-enable and ODT buffers
// - Self refresh keeps only clock-enable buffer
// - Chip select high masks every command
// - Four strobe levels encode the command
// - Masked write beats are not stored
// - Masks sampled on both strobe edges
// - Lower mask lower byte, upper mask upper
// - Bank address picks the target bank
// - Bank address picks mode register on load
// - Burst length four or eight
// - Column latency three to six cycles
// - Additive latency zero to four cycles
// - Write latency is read latency minus one
// - Four banks, each with own open row
// - Address bit ten: one or all banks
// - Address carries mode register op-code
// - Complement strobe only in differential mode
`timescale 1ns/1ps
`default_nettype none
module dsc_core import dsc_pkg::*; #(
  parameter int DQ_W = 72,
  parameter int DIES = 5,
  parameter int PIPE_D = 9
) (
  // Core clock and reset
  input wire logic clock,
  input wire logic reset,
  // Link clock and command pins
  input wire logic link_clock,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic odt,
  // Write beats, one per strobe edge
  input wire logic [DQ_W-1:0] dq_rise,
  input wire logic [DQ_W-1:0] dq_fall,
  input wire logic [2*DIES-1:0] dm_rise,
  input wire logic [2*DIES-1:0] dm_fall,
  // Read beats and pad drive enables
  output logic [DQ_W-1:0] dq_out_rise,
  output logic [DQ_W-1:0] dq_out_fall,
  output logic dq_oe,
  output logic dqs_oe,
  output logic dqs_n_oe,
  // Pad and clocking control
  output logic term_on,
  output logic inbuf_cmd_en,
  output logic inbuf_odt_en,
  output logic clk_run,
  // Status in the core domain
  output logic [1:0] stat_power,
  output logic [BANKS-1:0] stat_banks,
  output logic stat_term,
  output logic stat_burst8,
  output logic [LAT_W-1:0] stat_cas_lat,
  output logic [LAT_W-1:0] stat_add_lat
);

  localparam int BYTES = DQ_W / 8;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [2:0] lat_clamp(input logic [2:0] v, input logic [2:0] lo,
                                           input logic [2:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction

  // Word index of one beat, wrapping inside the burst
  function automatic logic [MEM_AW-1:0] beat_idx(input logic [BA_W-1:0] bank,
                                                 input logic [COL_KEEP_W-1:0] col,
                                                 input logic [2:0] beat, input logic b8);
    logic [COL_KEEP_W-1:0] c;
    c = col;
    if (b8) begin
      c[2:0] = col[2:0] + beat;
    end else begin
      c[1:0] = col[1:0] + beat[1:0];
    end
    return {bank, c};
  endfunction

  // ****************************************
  // Link domain reset and pin capture
  // ****************************************
  logic lrst_meta;
  logic lrst;
  logic cke_q;
  logic cs_q;
  logic ras_q;
  logic cas_q;
  logic we_q;
  logic odt_q;
  logic [BA_W-1:0] ba_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DQ_W-1:0] dq_rise_q;
  logic [DQ_W-1:0] dq_fall_q;
  logic [2*DIES-1:0] dm_rise_q;
  logic [2*DIES-1:0] dm_fall_q;
  dsc_cmd_t cmd;
  dsc_power_t pw;
  dsc_power_t next_pw;
  logic cmd_go;

  // Reset released on the link clock
  always_ff @(posedge link_clock or posedge reset) begin
    if (reset) begin
      lrst_meta <= 1'b1;
      lrst <= 1'b1;
    end else begin
      lrst_meta <= 1'b0;
      lrst <= lrst_meta;
    end
  end

  // Control pins, with disabled buffers reading as idle
  always_ff @(posedge link_clock or posedge lrst) begin
    if (lrst) begin
      cke_q <= 1'b1; // Awake out of reset, so no false power-down entry
      cs_q <= 1'b1;
      ras_q <= 1'b1;
      cas_q <= 1'b1;
      we_q <= 1'b1;
      ba_q <= '0;
      addr_q <= '0;
      odt_q <= 1'b0;
    end else begin
      cke_q <= cke;
      if (inbuf_cmd_en) begin
        cs_q <= cs_n;
        ras_q <= ras_n;
        cas_q <= cas_n;
        we_q <= we_n;
        ba_q <= ba;
        addr_q <= addr;
      end else begin
        cs_q <= 1'b1;
      end
      odt_q <= inbuf_odt_en ? odt : 1'b0;
    end
  end

  // Beat and mask capture, both strobe edges presented per cycle
  always_ff @(posedge link_clock) begin
    dq_rise_q <= dq_rise;
    dq_fall_q <= dq_fall;
    dm_rise_q <= dm_rise;
    dm_fall_q <= dm_fall;
  end

  // ****************************************
  // Command decode
  // ****************************************
  dsc_cmd_if cmd_bus ();

  assign cmd_bus.cs_n = cs_q;
  assign cmd_bus.ras_n = ras_q;
  assign cmd_bus.cas_n = cas_q;
  assign cmd_bus.we_n = we_q;
  assign cmd = cmd_bus.cmd;

  dsc_decode u_decode (
    .bus(cmd_bus)
  );

  // Commands act only while awake and clock enable held high, except refresh with it low, which enters self refresh
  assign cmd_go = cke_q && (pw == PW_ACTIVE);

  // ****************************************
  // Mode registers
  // ****************************************
  logic [ADDR_W-1:0] mode_reg [MODE_REGS];
  logic burst8;
  logic [2:0] cas_lat;
  logic [2:0] add_lat;
  logic rtt_on;
  logic dqsn_off;
  logic [3:0] read_lat;
  logic [3:0] tap;

  // Load the selected mode register with the address op-code
  always_ff @(posedge link_clock or posedge lrst) begin
    if (lrst) begin
      mode_reg[MR_BASE] <= MR_RESET;
      for (int i = 1; i < MODE_REGS; i++) begin
        mode_reg[i] <= EMR_RESET;
      end
    end else if (cmd_go && cmd == CMD_MODE) begin
      mode_reg[ba_q] <= addr_q;
    end
  end

  // Fields decoded from the mode registers
  assign burst8 = mode_reg[MR_BASE][BL_LSB +: 3] == BL8_CODE;
  assign cas_lat = lat_clamp(mode_reg[MR_BASE][CL_LSB +: 3], CL_MIN, CL_MAX);
  assign add_lat = lat_clamp(mode_reg[EMR_ONE][AL_LSB +: 3], AL_MIN, AL_MAX);
  assign rtt_on = mode_reg[EMR_ONE][RTT_LO_BIT] | mode_reg[EMR_ONE][RTT_HI_BIT];
  assign dqsn_off = mode_reg[EMR_ONE][DQSN_OFF_BIT];
  assign read_lat = {1'b0, cas_lat} + {1'b0, add_lat};
  // Read and write share one tap since write latency is one less
  assign tap = read_lat - LAT_TAP_SUB;

  // ****************************************
  // Power states
  // ****************************************
  logic [BANKS-1:0] bank_open;

  // Clock enable low picks the low-power state
  always_comb begin
    next_pw = pw;
    case (pw)
      PW_ACTIVE: begin
        if (!cke_q) begin
          if (cmd == CMD_REFRESH) begin
            next_pw = PW_SELF_REF;
          end else if (|bank_open) begin
            next_pw = PW_ACT_PD;
          end else begin
            next_pw = PW_PRE_PD;
          end
        end
      end
      PW_PRE_PD, PW_ACT_PD: begin
        if (cke_q) begin
          next_pw = PW_ACTIVE;
        end
      end
      PW_SELF_REF: begin
        if (cke) begin
          next_pw = PW_ACTIVE;
        end
      end
      default: next_pw = PW_ACTIVE;
    endcase
  end

  // State, clocking and input buffer enables
  always_ff @(posedge link_clock or posedge lrst) begin
    if (lrst) begin
      pw <= PW_ACTIVE;
      clk_run <= 1'b1;
      inbuf_cmd_en <= 1'b1;
      inbuf_odt_en <= 1'b1;
    end else begin
      pw <= next_pw;
      clk_run <= next_pw == PW_ACTIVE;
      inbuf_cmd_en <= next_pw == PW_ACTIVE;
      inbuf_odt_en <= next_pw != PW_SELF_REF;
    end
  end

  // ****************************************
  // Banks
  // ****************************************
  logic [ADDR_W-1:0] bank_row [BANKS];

  // Open and close rows per bank
  always_ff @(posedge link_clock or posedge lrst) begin
    if (lrst) begin
      bank_open <= '0;
      for (int i = 0; i < BANKS; i++) begin
        bank_row[i] <= '0;
      end
    end else if (cmd_go) begin
      case (cmd)
        CMD_ACTIVE: begin
          bank_open[ba_q] <= 1'b1;
          bank_row[ba_q] <= addr_q;
        end
        CMD_PRECHARGE: begin
          if (addr_q[AUTO_PRE_BIT]) begin
            bank_open <= '0;
          end else begin
            bank_open[ba_q] <= 1'b0;
          end
        end
        CMD_READ, CMD_WRITE: begin
          if (addr_q[AUTO_PRE_BIT]) begin
            bank_open[ba_q] <= 1'b0; // Auto precharge
          end
        end
        default: bank_open <= bank_open;
      endcase
    end
  end

  // ****************************************
  // Column command latency line
  // ****************************************
  logic pipe_v [PIPE_D];
  dsc_col_t pipe [PIPE_D];

  // One stage per link cycle after the column command
  always_ff @(posedge link_clock or posedge lrst) begin
    if (lrst) begin
      for (int i = 0; i < PIPE_D; i++) begin
        pipe_v[i] <= 1'b0;
        pipe[i] <= '0;
      end
    end else begin
      pipe_v[0] <= cmd_go && (cmd == CMD_READ || cmd == CMD_WRITE);
      pipe[0] <= '{wr: cmd == CMD_WRITE, bank: ba_q, col: addr_q[COL_KEEP_W-1:0]};
      for (int i = 1; i < PIPE_D; i++) begin
        pipe_v[i] <= pipe_v[i-1];
        pipe[i] <= pipe[i-1];
      end
    end
  end

  // ****************************************
  // Burst engine
  // ****************************************
  logic [2:0] bst_left;
  logic [2:0] bst_step;
  logic bst_b8;
  dsc_col_t bst;
  logic cur_v;
  logic [2:0] cur_step;
  logic cur_b8;
  dsc_col_t cur;
  logic [MEM_AW-1:0] idx_rise;
  logic [MEM_AW-1:0] idx_fall;

  // A command reaching the tap starts or cuts in on a burst
  always_comb begin
    if (pipe_v[tap]) begin
      cur_v = 1'b1;
      cur = pipe[tap];
      cur_step = 3'h0;
      cur_b8 = burst8;
    end else begin
      cur_v = bst_left != 3'h0;
      cur = bst;
      cur_step = bst_step;
      cur_b8 = bst_b8;
    end
    idx_rise = beat_idx(cur.bank, cur.col, {cur_step[1:0], 1'b0}, cur_b8);
    idx_fall = beat_idx(cur.bank, cur.col, {cur_step[1:0], 1'b1}, cur_b8);
  end

  // Count out the remaining beat pairs
  always_ff @(posedge link_clock or posedge lrst) begin
    if (lrst) begin
      bst_left <= 3'h0;
      bst_step <= 3'h0;
      bst_b8 <= 1'b0;
      bst <= '0;
    end else if (pipe_v[tap]) begin
      bst_left <= (burst8 ? BL8_CYC : BL4_CYC) - 3'h1;
      bst_step <= 3'h1;
      bst_b8 <= burst8;
      bst <= pipe[tap];
    end else if (bst_left != 3'h0) begin
      bst_left <= bst_left - 3'h1;
      bst_step <= bst_step + 3'h1;
    end
  end

  // ****************************************
  // Storage array
  // ****************************************
  logic [DQ_W-1:0] mem [2**MEM_AW];

  // Unmasked bytes of both beats are stored
  always_ff @(posedge link_clock) begin
    if (cur_v && cur.wr) begin
      for (int b = 0; b < BYTES; b++) begin
        if (!dm_rise_q[b]) begin
          mem[idx_rise][b*8 +: 8] <= dq_rise_q[b*8 +: 8];
        end
        if (!dm_fall_q[b]) begin
          mem[idx_fall][b*8 +: 8] <= dq_fall_q[b*8 +: 8];
        end
      end
    end
  end

  // Read beats and strobe enables launched on the link clock
  always_ff @(posedge link_clock or posedge lrst) begin
    if (lrst) begin
      dq_out_rise <= '0;
      dq_out_fall <= '0;
      dq_oe <= 1'b0;
      dqs_oe <= 1'b0;
      dqs_n_oe <= 1'b0;
    end else begin
      dq_out_rise <= mem[idx_rise];
      dq_out_fall <= mem[idx_fall];
      dq_oe <= cur_v && !cur.wr;
      dqs_oe <= cur_v && !cur.wr;
      dqs_n_oe <= cur_v && !cur.wr && !dqsn_off;
    end
  end

  // ****************************************
  // Termination
  // ****************************************
  // One enable for the data, mask and strobe pads
  always_ff @(posedge link_clock or posedge lrst) begin
    if (lrst) begin
      term_on <= 1'b0;
    end else begin
      term_on <= odt_q && rtt_on;
    end
  end

  // ****************************************
  // Status toward the core clock
  // ****************************************
  logic [STAT_W-1:0] stat_link;
  logic [STAT_W-1:0] stat_core;

  // Status word held in a link flop before crossing
  always_ff @(posedge link_clock or posedge lrst) begin
    if (lrst) begin
      stat_link <= '0;
    end else begin
      stat_link <= {pw, bank_open, term_on, burst8, cas_lat, add_lat};
    end
  end

  dsc_sync #(
    .W(STAT_W)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .din(stat_link),
    .dout(stat_core)
  );

  assign {stat_power, stat_banks, stat_term, stat_burst8, stat_cas_lat, stat_add_lat} =
    stat_core;

endmodule // dsc_core
`default_nettype wire

// file: src/dsc_decode.sv
`timescale 1ns/1ps
`default_nettype none
module dsc_decode import dsc_pkg::*; (
  // Command strobes in, command out
  dsc_cmd_if.dec bus
);

  // Chip select masks everything, else the three strobes pick the command
  always_comb begin
    if (bus.cs_n) begin
      bus.cmd = CMD_DESELECT;
    end else begin
      case ({bus.ras_n, bus.cas_n, bus.we_n})
        CODE_MODE: bus.cmd = CMD_MODE;
        CODE_REFRESH: bus.cmd = CMD_REFRESH;
        CODE_PRECHARGE: bus.cmd = CMD_PRECHARGE;
        CODE_ACTIVE: bus.cmd = CMD_ACTIVE;
        CODE_WRITE: bus.cmd = CMD_WRITE;
        CODE_READ: bus.cmd = CMD_READ;
        default: bus.cmd = CMD_NOP;
      endcase
    end
  end

endmodule // dsc_decode
`default_nettype wire

// file: src/dsc_pkg.sv
package dsc_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam int BANKS = 4;
  localparam int MODE_REGS = 4;
  localparam int COL_KEEP_W = 4;
  localparam int MEM_AW = BA_W + COL_KEEP_W;
  localparam int LAT_W = 3;
  localparam int STAT_W = 14;

  // ****************************************
  // Mode register fields
  // ****************************************
  localparam int MR_BASE = 0;
  localparam int EMR_ONE = 1;
  localparam int BL_LSB = 0;
  localparam int CL_LSB = 4;
  localparam int AL_LSB = 3;
  localparam int RTT_LO_BIT = 2;
  localparam int RTT_HI_BIT = 6;
  localparam int DQSN_OFF_BIT = 10;
  localparam int AUTO_PRE_BIT = 10;
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [ADDR_W-1:0] MR_RESET = 13'h0042;
  localparam logic [ADDR_W-1:0] EMR_RESET = 13'h0000;

  // ****************************************
  // Latencies and burst timing in link cycles
  // ****************************************
  localparam logic [2:0] CL_MIN = 3'h3;
  localparam logic [2:0] CL_MAX = 3'h6;
  localparam logic [2:0] AL_MIN = 3'h0;
  localparam logic [2:0] AL_MAX = 3'h4;
  localparam logic [3:0] LAT_TAP_SUB = 4'h2;
  localparam logic [2:0] BL4_CYC = 3'h2;
  localparam logic [2:0] BL8_CYC = 3'h4;

  // ****************************************
  // Command codes on row, column and write strobes
  // ****************************************
  localparam logic [2:0] CODE_MODE = 3'h0;
  localparam logic [2:0] CODE_REFRESH = 3'h1;
  localparam logic [2:0] CODE_PRECHARGE = 3'h2;
  localparam logic [2:0] CODE_ACTIVE = 3'h3;
  localparam logic [2:0] CODE_WRITE = 3'h4;
  localparam logic [2:0] CODE_READ = 3'h5;

  typedef enum logic [2:0] {CMD_DESELECT, CMD_NOP, CMD_MODE, CMD_REFRESH,
                            CMD_PRECHARGE, CMD_ACTIVE, CMD_WRITE, CMD_READ} dsc_cmd_t;
  typedef enum logic [1:0] {PW_ACTIVE, PW_PRE_PD, PW_ACT_PD, PW_SELF_REF} dsc_power_t;
  typedef struct packed {
    logic wr;
    logic [BA_W-1:0] bank;
    logic [COL_KEEP_W-1:0] col;
  } dsc_col_t;

endpackage

// file: src/dsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dsc_sync #(
  parameter int W = 8
) (
  // Destination clock and reset
  input wire logic clock,
  input wire logic reset,
  // Word from the other domain, word in this domain
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta;
  logic [W-1:0] stab;
  logic [W-1:0] prev;

  // Two flops, then take the word only once it reads the same twice
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta <= '0;
      stab <= '0;
      prev <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      stab <= meta;
      prev <= stab;
      if (stab == prev) begin
        dout <= stab; // Torn samples never repeat, so never pass
      end
    end
  end

endmodule // dsc_sync
`default_nettype wire
